// >>> src/drive_start_sequencer.sv
/*
 * Start sequencer of a variable-frequency drive: start delay, shorting or
 * DC braking, start frequency hold, then ramp to the set frequency.
 * Assumes a 100 MHz clock, asynchronous reset, and that the power stage
 * and the stop sequencer act on the outputs of this block.
 */
// Decided for this implementation: the placing of the registers and strobed register access.
// Summary of operation
// (R1) Start mode picks direct or braking start
// (R2) Direct start outputs configured start frequency
// (R3) Hold start frequency, then ramp upward
// (R4) Set below start frequency keeps standby
// (R5) Start frequency ignores lower frequency limit
// (R6) Braking mode brakes DC, then accelerates
// (R7) Zero braking time skips DC braking
// (R8) Brake current is percent of rated
// (R9) Run command waits the start delay
// (R10) Direct mode applies shorting brake time
// (R11) Delay, brake, hold, ramp in order
// (R12) Stop aborts start, hands to stop
`timescale 1ns/1ps
module drive_start_sequencer #(
    parameter int TICK_DIV = start_seq_pkg::TICK_CYCLES,
    parameter logic [15:0] RATED_CURRENT = 16'h03E8   // Rated output current, plain units
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic [15:0] OUT_FREQ,
    output logic OUT_ENABLE,
    output logic DC_BRAKE,
    output logic [15:0] DC_BRAKE_LEVEL,
    output logic SHORT_BRAKE,
    output logic STOP_HANDOFF,
    output logic RUNNING
);
    // ----------------------------------------------------------------
    // Settings
    // ----------------------------------------------------------------
    logic start_mode_select_q;              // 0 direct, 1 braking start
    logic [15:0] direct_start_frequency_q;  // 0.01 Hz
    logic [15:0] start_freq_hold_time_q;    // 0.01 s
    logic [15:0] prestart_brake_current_q;  // 0.1 %
    logic [15:0] prestart_brake_time_q;     // 0.01 s
    logic [15:0] run_start_delay_q;         // 0.01 s
    logic [15:0] shorting_brake_hold_for_start_q; // 0.01 s
    logic [15:0] set_freq_q;                // 0.01 Hz
    logic run_cmd_q;                        // Pulse from a run write
    logic stop_cmd_q;                       // Pulse from a stop write
    // Sequencer state
    start_seq_pkg::phase_type phase_q;
    logic [15:0] timer_q;                   // Remaining 0.01 s ticks
    logic tick;                             // 0.01 s enable
    logic [31:0] level_prod;                // Scaled braking level

    // Clamp a written value to its range
    function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] mx);
        clamp16 = (v[31:16] != 16'h0 || v[15:0] > mx) ? mx : v[15:0];
    endfunction

    // Phase length in ticks: one extra tick covers the partial first tick,
    // so a timed phase never ends early against the free-running divider
    function automatic logic [15:0] span16(input logic [15:0] v);
        span16 = (v == start_seq_pkg::ZERO16) ? start_seq_pkg::ZERO16 : v + 16'h1;
    endfunction

    tick_divider #(.DIV(TICK_DIV)) u_tick (
        .clk(REF_CLK),
        .rst(RST),
        .tick(tick)
    );

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            start_mode_select_q <= 1'b0;
            direct_start_frequency_q <= start_seq_pkg::START_FREQ_RST;
            start_freq_hold_time_q <= start_seq_pkg::ZERO16;
            prestart_brake_current_q <= start_seq_pkg::ZERO16;
            prestart_brake_time_q <= start_seq_pkg::ZERO16;
            run_start_delay_q <= start_seq_pkg::ZERO16;
            shorting_brake_hold_for_start_q <= start_seq_pkg::ZERO16;
            set_freq_q <= start_seq_pkg::ZERO16;
            run_cmd_q <= 1'b0;
            stop_cmd_q <= 1'b0;
        end else begin
            run_cmd_q <= 1'b0;
            stop_cmd_q <= 1'b0;
            if (WR) begin
                if (ADDR == start_seq_pkg::ADDR_CONTROL) begin
                    // (R1) start mode setting
                    start_mode_select_q <= WDATA[start_seq_pkg::CTRL_MODE_BIT];
                    run_cmd_q <= WDATA[start_seq_pkg::CTRL_RUN_BIT];
                    stop_cmd_q <= WDATA[start_seq_pkg::CTRL_STOP_BIT];
                end else if (ADDR == start_seq_pkg::ADDR_START_FREQ) begin
                    direct_start_frequency_q <= clamp16(WDATA, start_seq_pkg::START_FREQ_MAX);
                end else if (ADDR == start_seq_pkg::ADDR_HOLD_TIME) begin
                    start_freq_hold_time_q <= clamp16(WDATA, start_seq_pkg::TIME50_MAX);
                end else if (ADDR == start_seq_pkg::ADDR_BRK_CURR) begin
                    prestart_brake_current_q <= clamp16(WDATA, start_seq_pkg::CURR_MAX);
                end else if (ADDR == start_seq_pkg::ADDR_BRK_TIME) begin
                    prestart_brake_time_q <= clamp16(WDATA, start_seq_pkg::TIME50_MAX);
                end else if (ADDR == start_seq_pkg::ADDR_DELAY) begin
                    run_start_delay_q <= clamp16(WDATA, start_seq_pkg::DELAY_MAX);
                end else if (ADDR == start_seq_pkg::ADDR_SHORT_TIME) begin
                    shorting_brake_hold_for_start_q <= clamp16(WDATA, start_seq_pkg::TIME50_MAX);
                end else if (ADDR == start_seq_pkg::ADDR_SET_FREQ) begin
                    set_freq_q <= WDATA[15:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Register reads, data one cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 32'h0;
        end else if (RD) begin
            if (ADDR == start_seq_pkg::ADDR_CONTROL) begin
                RDATA <= {29'h0, start_mode_select_q, 2'h0};
            end else if (ADDR == start_seq_pkg::ADDR_START_FREQ) begin
                RDATA <= {16'h0, direct_start_frequency_q};
            end else if (ADDR == start_seq_pkg::ADDR_HOLD_TIME) begin
                RDATA <= {16'h0, start_freq_hold_time_q};
            end else if (ADDR == start_seq_pkg::ADDR_BRK_CURR) begin
                RDATA <= {16'h0, prestart_brake_current_q};
            end else if (ADDR == start_seq_pkg::ADDR_BRK_TIME) begin
                RDATA <= {16'h0, prestart_brake_time_q};
            end else if (ADDR == start_seq_pkg::ADDR_DELAY) begin
                RDATA <= {16'h0, run_start_delay_q};
            end else if (ADDR == start_seq_pkg::ADDR_SHORT_TIME) begin
                RDATA <= {16'h0, shorting_brake_hold_for_start_q};
            end else if (ADDR == start_seq_pkg::ADDR_SET_FREQ) begin
                RDATA <= {16'h0, set_freq_q};
            end else if (ADDR == start_seq_pkg::ADDR_STATUS) begin
                // Phase in bits 18:16, output frequency below
                RDATA <= {13'h0, 3'(phase_q), OUT_FREQ};
            end else begin
                // Unmapped addresses read zero
                RDATA <= 32'h0;
            end
        end else begin
            RDATA <= 32'h0;
        end
    end

    // (R8) level scaled from rated current
    assign level_prod = prestart_brake_current_q * RATED_CURRENT;

    // ----------------------------------------------------------------
    // Start sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            phase_q <= start_seq_pkg::PH_IDLE;
            timer_q <= start_seq_pkg::ZERO16;
            OUT_FREQ <= start_seq_pkg::ZERO16;
            OUT_ENABLE <= 1'b0;
            DC_BRAKE <= 1'b0;
            DC_BRAKE_LEVEL <= start_seq_pkg::ZERO16;
            SHORT_BRAKE <= 1'b0;
            STOP_HANDOFF <= 1'b0;
            RUNNING <= 1'b0;
        end else begin
            STOP_HANDOFF <= 1'b0;
            DC_BRAKE_LEVEL <= 16'(level_prod / 32'd1000);
            if (stop_cmd_q && phase_q != start_seq_pkg::PH_IDLE) begin
                // (R12) stop aborts start
                phase_q <= start_seq_pkg::PH_IDLE;
                STOP_HANDOFF <= 1'b1;
                // Power stage output goes off with the handoff
                OUT_ENABLE <= 1'b0;
                OUT_FREQ <= start_seq_pkg::ZERO16;
                DC_BRAKE <= 1'b0;
                SHORT_BRAKE <= 1'b0;
                RUNNING <= 1'b0;
            end else begin
                case (phase_q)
                    start_seq_pkg::PH_IDLE: begin
                        OUT_ENABLE <= 1'b0;
                        OUT_FREQ <= start_seq_pkg::ZERO16;
                        // (R4) refuse when set below start
                        if (run_cmd_q && set_freq_q >= direct_start_frequency_q) begin
                            // (R9) wait start delay first
                            phase_q <= start_seq_pkg::PH_DELAY;
                            timer_q <= span16(run_start_delay_q);
                            RUNNING <= 1'b1;
                        end
                    end
                    start_seq_pkg::PH_DELAY: begin
                        if (timer_q == start_seq_pkg::ZERO16) begin
                            // (R11) delay then braking phase
                            if (start_mode_select_q == 1'b0) begin
                                // (R10) shorting brake when non-zero
                                phase_q <= (shorting_brake_hold_for_start_q != start_seq_pkg::ZERO16) ?
                                    start_seq_pkg::PH_SHORT : start_seq_pkg::PH_HOLD;
                                timer_q <= span16((shorting_brake_hold_for_start_q != start_seq_pkg::ZERO16) ?
                                    shorting_brake_hold_for_start_q : start_freq_hold_time_q);
                                SHORT_BRAKE <= (shorting_brake_hold_for_start_q != start_seq_pkg::ZERO16);
                            end else begin
                                // (R7) zero brake time skips braking
                                phase_q <= (prestart_brake_time_q != start_seq_pkg::ZERO16) ?
                                    start_seq_pkg::PH_DCBRK : start_seq_pkg::PH_HOLD;
                                timer_q <= span16((prestart_brake_time_q != start_seq_pkg::ZERO16) ?
                                    prestart_brake_time_q : start_freq_hold_time_q);
                                DC_BRAKE <= (prestart_brake_time_q != start_seq_pkg::ZERO16);
                            end
                        end else if (tick) begin
                            timer_q <= timer_q - 16'h1;
                        end
                    end
                    start_seq_pkg::PH_SHORT, start_seq_pkg::PH_DCBRK: begin
                        // (R6) brake for full time, then hold
                        if (timer_q == start_seq_pkg::ZERO16) begin
                            phase_q <= start_seq_pkg::PH_HOLD;
                            timer_q <= span16(start_freq_hold_time_q);
                            DC_BRAKE <= 1'b0;
                            SHORT_BRAKE <= 1'b0;
                        end else if (tick) begin
                            timer_q <= timer_q - 16'h1;
                        end
                    end
                    start_seq_pkg::PH_HOLD: begin
                        // (R2) output starts at start frequency
                        // (R5) no lower limit clamp applied
                        OUT_ENABLE <= 1'b1;
                        OUT_FREQ <= direct_start_frequency_q;
                        // (R3) hold then ramp
                        if (timer_q == start_seq_pkg::ZERO16) begin
                            phase_q <= start_seq_pkg::PH_RAMP;
                        end else if (tick) begin
                            timer_q <= timer_q - 16'h1;
                        end
                    end
                    start_seq_pkg::PH_RAMP: begin
                        // (R3) ramp toward set frequency
                        if (OUT_FREQ >= set_freq_q) begin
                            OUT_FREQ <= set_freq_q;
                            phase_q <= start_seq_pkg::PH_RUN;
                        end else if (tick) begin
                            OUT_FREQ <= OUT_FREQ + start_seq_pkg::RAMP_STEP;
                        end
                    end
                    start_seq_pkg::PH_RUN: begin
                        // Track set frequency once started
                        OUT_FREQ <= set_freq_q;
                    end
                    default: begin
                        phase_q <= start_seq_pkg::PH_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// >>> common/start_seq_pkg.sv
/*
 * Package for the drive start sequencer: register offsets, reset values,
 * timing constants and the phase enumeration.
 * Assumes a 100 MHz system clock and a plain strobe register port.
 */
package start_seq_pkg;
    // ----------------------------------------------------------------
    // Clock and time base
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 100000000;
    localparam int TICK_MS = 10;                              // Time unit of settings, 0.01 s
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;     // Cycles per 0.01 s
    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;     // Run/stop command, start mode
    localparam logic [7:0] ADDR_START_FREQ = 8'h04;  // Direct start frequency, 0.01 Hz
    localparam logic [7:0] ADDR_HOLD_TIME = 8'h08;   // Start frequency hold, 0.01 s
    localparam logic [7:0] ADDR_BRK_CURR = 8'h0C;    // Pre-start brake current, 0.1 %
    localparam logic [7:0] ADDR_BRK_TIME = 8'h10;    // Pre-start brake time, 0.01 s
    localparam logic [7:0] ADDR_DELAY = 8'h14;       // Run start delay, 0.01 s
    localparam logic [7:0] ADDR_SHORT_TIME = 8'h18;  // Shorting brake hold, 0.01 s
    localparam logic [7:0] ADDR_SET_FREQ = 8'h1C;    // Set frequency, 0.01 Hz
    localparam logic [7:0] ADDR_STATUS = 8'h20;      // Phase and output frequency
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int CTRL_MODE_BIT = 2;
    localparam logic [15:0] START_FREQ_RST = 16'h0032;  // 0.50 Hz
    localparam logic [15:0] START_FREQ_MAX = 16'h1388;  // 50.00 Hz
    localparam logic [15:0] TIME50_MAX = 16'h1388;      // 50.00 s
    localparam logic [15:0] DELAY_MAX = 16'hEA60;       // 600.00 s
    localparam logic [15:0] CURR_MAX = 16'h03E8;        // 100.0 %
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [15:0] RAMP_STEP = 16'h0001;       // 0.01 Hz per ramp tick
    // ----------------------------------------------------------------
    // Sequencer phases
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE, PH_DELAY, PH_SHORT, PH_DCBRK, PH_HOLD, PH_RAMP, PH_RUN, PH_ABORT
    } phase_type;
endpackage

// >>> src/tick_divider.sv
/*
 * Divider that makes a one-cycle enable pulse every DIV cycles.
 * Assumes one clock domain and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module tick_divider #(
    parameter int DIV = start_seq_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    // Cycle counter
    logic [31:0] cnt_q;

    // ----------------------------------------------------------------
    // Counter and pulse
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_q == 32'(DIV - 1)) begin
            cnt_q <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

// >>> verif/drive_start_sequencer_properties.sv
/* Port checker of the start sequencer.
   Assumes it is bound to drive_start_sequencer and sees only its ports. */
`timescale 1ns/1ps
module drive_start_sequencer_properties (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic [15:0] OUT_FREQ,
    input wire logic OUT_ENABLE,
    input wire logic DC_BRAKE,
    input wire logic [15:0] DC_BRAKE_LEVEL,
    input wire logic SHORT_BRAKE,
    input wire logic STOP_HANDOFF,
    input wire logic RUNNING
);
    // ----------------------------------------------------------------
    // Sequencing and read data properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    a_brakes_exclusive: assert property (!(DC_BRAKE && SHORT_BRAKE))
        else $error("both brakes active");
    a_idle_quiet: assert property (!RUNNING |-> !OUT_ENABLE && !DC_BRAKE && !SHORT_BRAKE)
        else $error("output while idle");
    a_dc_no_output: assert property (DC_BRAKE |-> !OUT_ENABLE)
        else $error("output during dc braking");
    a_short_no_output: assert property (SHORT_BRAKE |-> !OUT_ENABLE)
        else $error("output during shorting brake");
    a_dc_then_hold: assert property ($fell(DC_BRAKE) |-> ##[0:3] (OUT_ENABLE || !RUNNING || STOP_HANDOFF))
        else $error("no hold after dc braking");
    a_short_then_hold: assert property ($fell(SHORT_BRAKE) |-> ##[0:3] (OUT_ENABLE || !RUNNING || STOP_HANDOFF))
        else $error("no hold after shorting brake");
    a_ramp_step: assert property (OUT_ENABLE && $past(OUT_ENABLE) && !STOP_HANDOFF && !$past(STOP_HANDOFF)
        |-> (OUT_FREQ - $past(OUT_FREQ)) inside {16'h0000, 16'h0001})
        else $error("output frequency step wrong");
    a_handoff_pulse: assert property (STOP_HANDOFF |=> !STOP_HANDOFF ##[0:3] !RUNNING)
        else $error("stop handoff not a single pulse");
    a_read_stands: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
        else $error("read data outside read cycle");
endmodule
bind drive_start_sequencer drive_start_sequencer_properties drive_start_sequencer_properties_inst (
    .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .OUT_FREQ(OUT_FREQ), .OUT_ENABLE(OUT_ENABLE), .DC_BRAKE(DC_BRAKE), .DC_BRAKE_LEVEL(DC_BRAKE_LEVEL),
    .SHORT_BRAKE(SHORT_BRAKE), .STOP_HANDOFF(STOP_HANDOFF), .RUNNING(RUNNING));

// >>> verif/motor_model.sv
/* Motor behind the power stage: speed follows the drive, brakes hold it.
   Assumes the sequencer outputs as its only inputs. */
`timescale 1ns/1ps
module motor_model (
    input wire logic clk,
    input wire logic [15:0] freq,
    input wire logic drive_on,
    input wire logic dc_hold,
    input wire logic short_hold,
    output int speed,
    output logic locked
);
    // Speed tracks output, brakes stop it, otherwise it coasts down
    always @(posedge clk) begin
        locked <= dc_hold || short_hold;
        if (drive_on) begin
            speed <= int'(freq);
        end else if (dc_hold || short_hold) begin
            speed <= 0;
        end else if (speed > 0) begin
            speed <= speed - 1;
        end
    end
    initial speed = 0;
endmodule

// >>> verif/tb_drive_start_sequencer.sv
/* Self-checking bench of the start sequencer with a motor model.
   Assumes a shortened tick; expectations come from the setting values. */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: got %0h want %0h", $time, (a), (b)); end end
module tb_drive_start_sequencer;
    localparam int TD = 4;  // Cycles per tick in simulation
    logic REF_CLK, RST, WR, RD;
    logic [7:0] ADDR;
    logic [31:0] WDATA, RDATA, r;
    logic [15:0] OUT_FREQ, DC_BRAKE_LEVEL, rnd = 16'h002A, start_f = 16'h0014, tgt, cur;
    logic OUT_ENABLE, DC_BRAKE, SHORT_BRAKE, STOP_HANDOFF, RUNNING, motor_locked, p_dc, p_sh, p_en;
    int num_errors = 0, total_checks = 0, pre_cnt, dc_cnt, sh_cnt, hold_cnt, hand_cnt, motor_speed;
    int seen[$], want[$];  // Observed and modelled phase order
    int tm[4] = '{0, 1, 1, 0}, tdl[4] = '{3, 0, 1, 0}, tsh[4] = '{2, 0, 2, 0};
    int tbk[4] = '{0, 3, 0, 0}, thd[4] = '{2, 1, 0, 0};
    drive_start_sequencer #(.TICK_DIV(TD), .RATED_CURRENT(16'h07D0)) drive_start_sequencer_inst (
        .REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .OUT_FREQ(OUT_FREQ), .OUT_ENABLE(OUT_ENABLE), .DC_BRAKE(DC_BRAKE), .DC_BRAKE_LEVEL(DC_BRAKE_LEVEL),
        .SHORT_BRAKE(SHORT_BRAKE), .STOP_HANDOFF(STOP_HANDOFF), .RUNNING(RUNNING));
    motor_model motor_model_inst (.clk(REF_CLK), .freq(OUT_FREQ), .drive_on(OUT_ENABLE),
        .dc_hold(DC_BRAKE), .short_hold(SHORT_BRAKE), .speed(motor_speed), .locked(motor_locked));
    // ----------------------------------------------------------------
    // Clock, monitor and helpers
    // ----------------------------------------------------------------
    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end
    // Phase time counters and order of phase entries
    always @(posedge REF_CLK) begin
        pre_cnt += (RUNNING && !OUT_ENABLE && !DC_BRAKE && !SHORT_BRAKE);
        dc_cnt += DC_BRAKE;
        sh_cnt += SHORT_BRAKE;
        hold_cnt += (OUT_ENABLE && OUT_FREQ === start_f);
        hand_cnt += STOP_HANDOFF;
        if (SHORT_BRAKE && !p_sh) seen.push_back(1);
        if (DC_BRAKE && !p_dc) seen.push_back(2);
        if (OUT_ENABLE && !p_en) seen.push_back(3);
        {p_sh, p_dc, p_en} = {SHORT_BRAKE, DC_BRAKE, OUT_ENABLE};
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic in_rng(input int v, input int lo);
        return v >= lo && v <= lo + TD + 4;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    // Bounded wait: 0 target reached, 1 idle, 2 dc braking
    task automatic wait_for(input int w);
        int n;
        for (n = 0; n < 3000; n++) begin
            @(posedge REF_CLK);
            #1;
            if (w == 0 && OUT_ENABLE && OUT_FREQ === tgt || w == 1 && RUNNING === 1'b0 || w == 2 && DC_BRAKE) break;
        end
        `CHK(n < 3000, 1'b1)
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #300000;
        num_errors++;
        tally_and_finish();
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        RST <= 1'b1;
        WR <= 1'b0;
        RD <= 1'b0;
        ADDR <= 8'h00;
        WDATA <= 32'h0;
        repeat (2) @(posedge REF_CLK);
        RST <= 1'b0;
        rd(start_seq_pkg::ADDR_START_FREQ, r); `CHK(r, 32'h0000_0032)
        rd(start_seq_pkg::ADDR_CONTROL, r); `CHK(r, 32'h0000_0000)
        rd(8'h24, r); `CHK(r, 32'h0000_0000)
        wr(start_seq_pkg::ADDR_START_FREQ, 32'h0000_FFFF);
        rd(start_seq_pkg::ADDR_START_FREQ, r); `CHK(r, 32'h0000_1388)
        // Set frequency below start frequency is refused
        wr(start_seq_pkg::ADDR_SET_FREQ, 32'h0000_0010);
        wr(start_seq_pkg::ADDR_CONTROL, 32'h1);
        repeat (20) @(posedge REF_CLK);
        `CHK(RUNNING, 1'b0)
        // Start frequency below any lower limit is still used
        wr(start_seq_pkg::ADDR_START_FREQ, {16'h0, start_f});
        for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            tgt = start_f + 16'h4 + (rnd & 16'h7);
            cur = rnd & 16'h03FF;
            wr(start_seq_pkg::ADDR_BRK_CURR, {16'h0, cur});
            wr(start_seq_pkg::ADDR_DELAY, tdl[i]);
            wr(start_seq_pkg::ADDR_SHORT_TIME, tsh[i]);
            wr(start_seq_pkg::ADDR_BRK_TIME, tbk[i]);
            wr(start_seq_pkg::ADDR_HOLD_TIME, thd[i]);
            wr(start_seq_pkg::ADDR_SET_FREQ, {16'h0, tgt});
            `CHK(DC_BRAKE_LEVEL, 16'((cur > 16'd1000 ? 16'd1000 : cur) * 2))
            {pre_cnt, dc_cnt, sh_cnt, hold_cnt, hand_cnt} = '0;
            seen = {};
            want = {};
            if (tm[i] == 0 && tsh[i] != 0) want.push_back(1);
            if (tm[i] == 1 && tbk[i] != 0) want.push_back(2);
            want.push_back(3);
            wr(start_seq_pkg::ADDR_CONTROL, 32'h1 | (tm[i] << 2));
            wait_for(0);
            `CHK(in_rng(pre_cnt, tdl[i] * TD), 1'b1)
            `CHK(tm[i] == 0 && tsh[i] != 0 ? in_rng(sh_cnt, tsh[i] * TD) : sh_cnt == 0, 1'b1)
            `CHK(tm[i] == 1 && tbk[i] != 0 ? in_rng(dc_cnt, tbk[i] * TD) : dc_cnt == 0, 1'b1)
            `CHK(in_rng(hold_cnt, thd[i] * TD), 1'b1)
            `CHK(seen == want, 1'b1)
            @(posedge REF_CLK);
            #1;
            `CHK(motor_speed == int'(tgt), 1'b1)
            rd(start_seq_pkg::ADDR_STATUS, r); `CHK(r, {13'h0, 3'(start_seq_pkg::PH_RUN), tgt})
            wr(start_seq_pkg::ADDR_CONTROL, 32'h2 | (tm[i] << 2));
            wait_for(1);
            @(posedge REF_CLK);
            #1;
            `CHK(hand_cnt, 1)
        end
        // Stop in the middle of dc braking aborts the start
        wr(start_seq_pkg::ADDR_BRK_TIME, 32'd50);
        wr(start_seq_pkg::ADDR_CONTROL, 32'h5);
        wait_for(2);
        @(posedge REF_CLK);
        #1;
        `CHK(motor_locked, 1'b1)
        hand_cnt = 0;
        wr(start_seq_pkg::ADDR_CONTROL, 32'h6);
        wait_for(1);
        @(posedge REF_CLK);
        #1;
        `CHK(hand_cnt, 1)
        `CHK(DC_BRAKE, 1'b0)
        // Reset in the middle of a start clears state and settings
        wr(start_seq_pkg::ADDR_CONTROL, 32'h1);
        repeat (4) @(posedge REF_CLK);
        RST <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        RST <= 1'b0;
        @(posedge REF_CLK);
        #1;
        `CHK({RUNNING, OUT_ENABLE, DC_BRAKE, SHORT_BRAKE}, 4'h0)
        rd(start_seq_pkg::ADDR_START_FREQ, r); `CHK(r, 32'h0000_0032)
        tally_and_finish();
    end
endmodule
